// >>> rtl/sgm_pkg.sv
package sgm_pkg;
   // Frame layout.
   localparam int FRAME_BITS = 40;
   localparam int BYTE_BITS = 8;
   localparam int NUM_CH = 8;
   localparam int ROUTE_BITS = 4;
   localparam int ROUTE_TOTAL = NUM_CH * ROUTE_BITS;
   localparam int CNT_W = 6;
   // Control byte field positions.
   localparam int CTL_START = 0;
   localparam int CTL_WRITE = 1;
   localparam int CTL_PWR_OFF = 2;
   localparam int CTL_ATT_LSB = 3;
   localparam int CTL_ATT_MSB = 4;
   localparam int CTL_SWEPT = 5;
   localparam int CTL_GAIN_LSB = 6;
   localparam int CTL_GAIN_MSB = 7;
   // Routing codes above this value tie the channel to the supply.
   localparam logic [3:0] ROUTE_MAX_OUT = 4'h9;
   // Attenuation in tenths of a dB for codes 00..11.
   localparam logic [9:0] ATT_29 = 10'h122;
   localparam logic [9:0] ATT_33 = 10'h14a;
   localparam logic [9:0] ATT_365 = 10'h16d;
   localparam logic [9:0] ATT_40 = 10'h190;
   // Gain in dB for codes 00 and 01.
   localparam logic [4:0] GAIN_21 = 5'h15;
   localparam logic [4:0] GAIN_26 = 5'h1a;
   // Host serial clock divider, half period in system cycles.
   localparam int SCLK_HALF_NS = 40;
   localparam int CLK_NS = 20;
   localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
   // Host register offsets.
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_ROUTE = 4'h1;
   localparam logic [3:0] ADDR_GO = 4'h2;
   localparam logic [3:0] ADDR_STATUS = 4'h3;
   localparam logic [3:0] ADDR_RX_CTRL = 4'h4;
   localparam logic [3:0] ADDR_RX_ROUTE = 4'h5;
endpackage

// >>> rtl/sgm_if.sv
interface sgm_if;
   logic sclk;
   logic cs_n;
   logic sdi;
   logic sdo;
   modport host (output sclk, output cs_n, output sdi, input sdo);
   modport dev (input sclk, input cs_n, input sdi, output sdo);
endinterface

// >>> rtl/sgm_dev.sv
// Behaviour
// [R1] Countdown of forty bits starts on first one
// [R2] Read frame keeps routing, still latches control
// [R3] Control bit two powers chip off
// [R4] Range bits select 29/33/36.5/40 dB
// [R5] Bit five picks swept gain or CW
// [R6] Gain select occupies bits six, seven
// [R7] Gain codes give 21 or 26 dB
// [R8] Byte nibbles route odd then even channel
// [R9] Codes 0-9 route, others tie supply
// [R10] Frame is five bytes, not eight
// [R11] Separate input and output data lines
// [R12] Read-back uses write stream order
// [R13] Read-back comes from shift stage
// [R14] Output always drives shifted data
// [R15] Host holds select low whole transfer
// [R16] Select may stay low permanently
// [R17] Host stops clock after configuring
// [R18] Bits go LSB first, control byte first
// [R19] Fields latched together after last bit
module sgm_dev
   import sgm_pkg::*;
(
   // Serial link, device end; the serial clock is this end's only clock.
   sgm_if.dev LINK,
   input wire logic RESETN_I,
   // Configuration outputs.
   output logic CHIP_POWER_OFF_O,
   output logic SWEPT_GAIN_MODE_O,
   output logic [1:0] ATTEN_RANGE_O,
   output logic [9:0] ATTEN_MAX_O,
   output logic [1:0] GAIN_SEL_O,
   output logic [4:0] GAIN_DB_O,
   output logic [sgm_pkg::ROUTE_TOTAL-1:0] ROUTE_O,
   output logic [sgm_pkg::NUM_CH-1:0] ROUTE_TIED_O
);
   import sgm_pkg::*;

   logic [FRAME_BITS-1:0] shift_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic [BYTE_BITS-1:0] ctrl_reg;
   logic [ROUTE_TOTAL-1:0] route_reg;
   logic active;
   logic last_bit;
   logic [FRAME_BITS-1:0] shift_next;

   assign active = (cnt_reg != '0);
   assign last_bit = (cnt_reg == CNT_W'(1));
   // New bits enter at the top so the first bit ends at bit zero.
   assign shift_next = {LINK.sdi, shift_reg[FRAME_BITS-1:1]}; // [R18]

   // Sample on rising edges; frame of forty bits only. [R10]
   always_ff @(posedge LINK.sclk or negedge RESETN_I) begin
      if (!RESETN_I) begin
         cnt_reg <= '0;
      end else if (LINK.cs_n) begin
         cnt_reg <= '0; // [R15]
      end else if (!active) begin
         // Idle bits are zeros; the start bit opens a frame. [R16]
         if (LINK.sdi) begin
            cnt_reg <= CNT_W'(FRAME_BITS - 1); // [R1]
         end
      end else begin
         cnt_reg <= cnt_reg - CNT_W'(1);
      end
   end

   // The shift stage runs whenever select is low.
   always_ff @(posedge LINK.sclk or negedge RESETN_I) begin
      if (!RESETN_I) begin
         shift_reg <= '0;
      end else if (!LINK.cs_n) begin
         shift_reg <= shift_next;
      end
   end

   // Latch control always, routing only on write frames. [R19]
   always_ff @(posedge LINK.sclk or negedge RESETN_I) begin
      if (!RESETN_I) begin
         ctrl_reg <= '0;
         route_reg <= '0;
      end else if (!LINK.cs_n && active && last_bit) begin
         ctrl_reg <= shift_next[BYTE_BITS-1:0]; // [R2]
         if (shift_next[CTL_WRITE]) begin
            route_reg <= shift_next[FRAME_BITS-1:BYTE_BITS]; // [R2] [R8]
         end
      end
   end

   // Output changes on the falling edge so the host samples it steadily.
   // It shows the shift stage, never the latched values. [R13]
   logic sdo_reg;
   always_ff @(negedge LINK.sclk or negedge RESETN_I) begin
      if (!RESETN_I) begin
         sdo_reg <= 1'b0;
      end else begin
         sdo_reg <= shift_reg[0]; // [R12] [R14]
      end
   end
   assign LINK.sdo = sdo_reg; // [R11]

   assign CHIP_POWER_OFF_O = ctrl_reg[CTL_PWR_OFF]; // [R3]
   assign SWEPT_GAIN_MODE_O = ctrl_reg[CTL_SWEPT]; // [R5]
   assign ATTEN_RANGE_O = {ctrl_reg[CTL_ATT_MSB], ctrl_reg[CTL_ATT_LSB]};
   assign GAIN_SEL_O = {ctrl_reg[CTL_GAIN_MSB], ctrl_reg[CTL_GAIN_LSB]};
   assign ROUTE_O = route_reg;

   // Decode of the attenuation range.
   always_comb begin
      unique case (ATTEN_RANGE_O)
         2'b00: ATTEN_MAX_O = ATT_29; // [R4]
         2'b01: ATTEN_MAX_O = ATT_33;
         2'b10: ATTEN_MAX_O = ATT_365;
         2'b11: ATTEN_MAX_O = ATT_40;
      endcase
   end

   // Undefined gain codes report zero. [R6] [R7]
   always_comb begin
      case (GAIN_SEL_O)
         2'b00: GAIN_DB_O = GAIN_21;
         2'b01: GAIN_DB_O = GAIN_26;
         default: GAIN_DB_O = '0;
      endcase
   end

   // Flag channels whose code ties them to the supply.
   for (genvar c = 0; c < NUM_CH; c++) begin : g_tie
      assign ROUTE_TIED_O[c] =
         route_reg[c*ROUTE_BITS +: ROUTE_BITS] > ROUTE_MAX_OUT; // [R9]
   end
endmodule

// >>> rtl/sgm_host.sv
// Strobed register access and the register offsets were decided locally.
module sgm_host
   import sgm_pkg::*;
(
   // Clock and reset.
   input wire logic MCLK_I,
   input wire logic RESETN_I,
   // Register port.
   input wire logic [3:0] ADDR_I,
   input wire logic [31:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [31:0] RDATA_O,
   // Serial link, host end.
   sgm_if.host LINK
);
   import sgm_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_LOW = 3'b010,
      ST_HIGH = 3'b100
   } sgm_st_e;

   sgm_st_e st_reg;
   logic [BYTE_BITS-1:0] ctrl_reg;
   logic [ROUTE_TOTAL-1:0] route_reg;
   logic [FRAME_BITS-1:0] tx_reg;
   logic [FRAME_BITS-1:0] rx_reg;
   logic [CNT_W-1:0] bit_reg;
   logic [3:0] div_reg;
   logic done_reg;
   logic sdo_s1_reg;
   logic sdo_s2_reg;
   logic tick;
   logic go;

   assign tick = (div_reg == 4'(SCLK_HALF_CYC - 1));
   assign go = WR_I && (ADDR_I == ADDR_GO) && (st_reg == ST_IDLE);

   // Software registers; a go is ignored while a frame runs.
   always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         ctrl_reg <= '0;
         route_reg <= '0;
      end else if (WR_I && ADDR_I == ADDR_CTRL) begin
         ctrl_reg <= WDATA_I[BYTE_BITS-1:0];
      end else if (WR_I && ADDR_I == ADDR_ROUTE) begin
         route_reg <= WDATA_I;
      end
   end

   // Incoming data passes two flip-flops first.
   always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         sdo_s1_reg <= 1'b0;
         sdo_s2_reg <= 1'b0;
      end else begin
         sdo_s1_reg <= LINK.sdo;
         sdo_s2_reg <= sdo_s1_reg;
      end
   end

   // Frame engine: clock low half drives data, high half ends a bit.
   always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         st_reg <= ST_IDLE;
         div_reg <= '0;
         bit_reg <= '0;
         tx_reg <= '0;
         rx_reg <= '0;
         done_reg <= 1'b0;
      end else begin
         unique case (st_reg)
            ST_IDLE: begin
               div_reg <= '0;
               if (go) begin
                  // Start bit forced to one, control byte sent first.
                  tx_reg <= {route_reg, ctrl_reg[BYTE_BITS-1:1], 1'b1};
                  bit_reg <= CNT_W'(FRAME_BITS);
                  done_reg <= 1'b0;
                  st_reg <= ST_LOW;
               end
            end
            ST_LOW: begin
               div_reg <= tick ? '0 : div_reg + 4'h1;
               if (tick) begin
                  st_reg <= ST_HIGH;
               end
            end
            ST_HIGH: begin
               div_reg <= tick ? '0 : div_reg + 4'h1;
               if (tick) begin
                  // Read-back replays the previous frame bit for bit.
                  rx_reg <= {sdo_s2_reg, rx_reg[FRAME_BITS-1:1]};
                  tx_reg <= {1'b0, tx_reg[FRAME_BITS-1:1]};
                  bit_reg <= bit_reg - CNT_W'(1);
                  if (bit_reg == CNT_W'(1)) begin
                     done_reg <= 1'b1;
                     st_reg <= ST_IDLE;
                  end else begin
                     st_reg <= ST_LOW;
                  end
               end
            end
         endcase
      end
   end

   // Clock rests low outside a frame, so the device sees no stray edges.
   assign LINK.sclk = (st_reg == ST_HIGH); // [R17]
   assign LINK.cs_n = (st_reg == ST_IDLE);
   assign LINK.sdi = (st_reg == ST_IDLE) ? 1'b0 : tx_reg[0];

   // Read data one cycle after the strobe.
   always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         RDATA_O <= '0;
      end else if (RD_I) begin
         unique case (ADDR_I)
            ADDR_CTRL: RDATA_O <= {24'h00_0000, ctrl_reg};
            ADDR_ROUTE: RDATA_O <= route_reg;
            ADDR_STATUS: RDATA_O <= {30'h0000_0000, done_reg,
                                     st_reg != ST_IDLE};
            ADDR_RX_CTRL: RDATA_O <= {24'h00_0000, rx_reg[BYTE_BITS-1:0]};
            ADDR_RX_ROUTE: RDATA_O <= rx_reg[FRAME_BITS-1:BYTE_BITS];
            default: RDATA_O <= 32'h0000_0000;
         endcase
      end else begin
         RDATA_O <= 32'h0000_0000;
      end
   end
endmodule

// >>> tb/sgm_link_asserts.sv
module sgm_link_asserts (
   // System clock and reset.
   input wire logic MCLK_I,
   input wire logic RESETN_I,
   // Serial link signals.
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdi,
   input wire logic sdo
);
   logic [6:0] bit_cnt_reg;
   logic sclk_q_reg;

   default clocking cb @(posedge MCLK_I);
   endclocking
   default disable iff (!RESETN_I);

   // Counts serial clock rises in a frame; a high select clears it.
   always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         bit_cnt_reg <= 7'h00;
         sclk_q_reg <= 1'b0;
      end else begin
         sclk_q_reg <= sclk;
         if (cs_n) begin
            bit_cnt_reg <= 7'h00;
         end else if (sclk && !sclk_q_reg) begin
            bit_cnt_reg <= bit_cnt_reg + 7'h01;
         end
      end
   end

   sclk_idle_a: assert property (cs_n |-> !sclk)
      else $error("serial clock high while deselected");
   start_bit_a: assert property ($fell(cs_n) |-> sdi)
      else $error("frame does not open with a one");
   first_rise_one_a: assert property
      (($rose(sclk) && bit_cnt_reg == 7'h00) |-> sdi)
      else $error("first sampled bit is not a one");
   data_steady_a: assert property
      ($rose(sclk) |-> $stable(sdi) && $stable(cs_n))
      else $error("data moved at the sampling edge");
   full_frame_a: assert property ($rose(cs_n) |-> bit_cnt_reg == 7'h28)
      else $error("frame closed without forty bits");
   frame_len_a: assert property ($fell(cs_n) |-> ##[150:250] cs_n)
      else $error("frame did not close in time");
   count_cap_a: assert property (bit_cnt_reg <= 7'h28)
      else $error("serial clock ran past forty bits");
   sdo_on_fall_a: assert property ($changed(sdo) |-> $fell(sclk))
      else $error("output data moved off the falling edge");

   // The main link events should all be seen at least once.
   cover property ($fell(cs_n));
   cover property ($rose(cs_n) && bit_cnt_reg == 7'h28);
   cover property ($changed(sdo));
endmodule

// >>> tb/sgm_tb_top.sv
module sgm_tb_top
   import sgm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk, resetn, wr, rd, pwr_o, swept_o;
   logic [3:0] addr;
   logic [31:0] wdata, rdata, route_o, d, rt, keep;
   logic [1:0] att_o, gain_o;
   logic [9:0] attmax_o;
   logic [4:0] gdb_o;
   logic [7:0] tied_o, tied_e, ctrl, keepc;
   logic [9:0] att_tab [4] = '{ATT_29, ATT_33, ATT_365, ATT_40};
   logic [4:0] gain_tab [4] = '{GAIN_21, GAIN_26, 5'h00, 5'h00};
   int fails = 0;
   int check_count = 0;

   sgm_if sgm_if_inst();
   sgm_host sgm_host_inst(.MCLK_I(mclk), .RESETN_I(resetn), .ADDR_I(addr),
      .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
      .LINK(sgm_if_inst.host));
   sgm_dev sgm_dev_inst(.LINK(sgm_if_inst.dev), .RESETN_I(resetn),
      .CHIP_POWER_OFF_O(pwr_o), .SWEPT_GAIN_MODE_O(swept_o),
      .ATTEN_RANGE_O(att_o), .ATTEN_MAX_O(attmax_o), .GAIN_SEL_O(gain_o),
      .GAIN_DB_O(gdb_o), .ROUTE_O(route_o), .ROUTE_TIED_O(tied_o));
   sgm_link_asserts sgm_link_asserts_inst(.MCLK_I(mclk), .RESETN_I(resetn),
      .sclk(sgm_if_inst.sclk), .cs_n(sgm_if_inst.cs_n),
      .sdi(sgm_if_inst.sdi), .sdo(sgm_if_inst.sdo));

   // Free-running system clock.
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   task automatic complete_run();
      $display("checks=%0d fails=%0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
      @(posedge mclk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe, so sample then.
   task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask

   // Sends one frame and waits, with a bound, for the done flag.
   task automatic frame(input logic [7:0] c, input logic [31:0] r);
      int n;
      n = 0;
      wr_reg(ADDR_CTRL, {24'h0000_00, c});
      wr_reg(ADDR_ROUTE, r);
      wr_reg(ADDR_GO, 32'h0000_0001);
      repeat (4) @(posedge mclk);
      d = 32'h0000_0000;
      while (d[1] !== 1'b1) begin
         rd_reg(ADDR_STATUS, d);
         n++;
         if (n > 400) begin
            fails++;
            complete_run();
         end
      end
   endtask

   task automatic expect_out(input logic [7:0] c, input logic [31:0] r);
      for (int k = 0; k < NUM_CH; k++) tied_e[k] = r[4*k+:4] > ROUTE_MAX_OUT;
      chk(32'(pwr_o), 32'(c[CTL_PWR_OFF]));
      chk(32'(swept_o), 32'(c[CTL_SWEPT]));
      chk(32'(att_o), 32'(c[4:3]));
      chk(32'(attmax_o), 32'(att_tab[c[4:3]]));
      chk(32'(gain_o), 32'(c[7:6]));
      chk(32'(gdb_o), 32'(gain_tab[c[7:6]]));
      chk(route_o, r);
      chk(32'(tied_o), 32'(tied_e));
   endtask

   // Main sequence: write frames over every field code, then a read frame.
   initial begin
      resetn = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 4'h0;
      wdata = 32'h0000_0000;
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         ctrl = {i[1:0], ~i[0], i[1:0], i[0], 2'b11};
         rt = 32'h9a3c_f051 ^ {8{i[3:0]}};
         frame(ctrl, rt);
         expect_out(ctrl, rt);
         $display("write frame %0d done", i);
      end
      keep = rt;
      keepc = ctrl;
      ctrl = 8'h55;
      frame(ctrl, 32'h1234_5678);
      expect_out(ctrl, keep);
      // The shift stage is forty bits deep, so it echoes the frame before.
      rd_reg(ADDR_RX_CTRL, d);
      chk(d, {24'h00_0000, keepc});
      rd_reg(ADDR_RX_ROUTE, d);
      chk(d, keep);
      $display("read frame done");
      rd_reg(4'hf, d);
      chk(d, 32'h0000_0000);
      rd_reg(ADDR_STATUS, d);
      chk(32'(d[1:0]), 32'h0000_0002);
      $display("register port test done");
      complete_run();
   end
endmodule
